// ### usrt_pkg.sv
// constants shared by the serial transceiver datapath
package usrt_pkg;
    // oversampling and vote positions
    localparam logic [4:0] USRT_SPB_NORMAL = 5'h10;
    localparam logic [4:0] USRT_SPB_DOUBLE = 5'h08;
    localparam logic [4:0] USRT_VOTE_NORMAL = 5'h08;
    localparam logic [4:0] USRT_VOTE_DOUBLE = 5'h04;
    localparam logic [4:0] USRT_VOTE_SPAN = 5'h02;
    // frame shape
    localparam logic [3:0] USRT_MIN_BITS = 4'h5;
    localparam logic [3:0] USRT_SPI_BITS = 4'h8;
    localparam logic [3:0] USRT_START_STOP = 4'h2;
    localparam int USRT_FRAME_W = 13;
    localparam int USRT_ENTRY_W = 12;
    // parity field: bit 1 enables, bit 0 selects odd
    localparam logic [1:0] USRT_PAR_NONE = 2'h0;
    localparam logic [1:0] USRT_PAR_EVEN = 2'h2;
    localparam logic [1:0] USRT_PAR_ODD = 2'h3;
    // receive entry field positions
    localparam int USRT_E_NINTH = 8;
    localparam int USRT_E_FRAME_ERROR_FLAG = 9;
    localparam int USRT_E_PARITY_ERROR_FLAG = 10;
    localparam int USRT_E_OVF = 11;
    // reset values and default receive fifo depth
    localparam logic USRT_RST_LINE = 1'b1;
    localparam int USRT_RX_DEPTH = 2;
endpackage

// ### usrt_datapath.sv
// transmit and receive datapath of the serial transceiver
`timescale 1ns/1ps
// Summary of operation
// - frame: low start, 5-9 data lsb first, optional parity, 1-2 high stops; idle high
// - even parity: parity bit one when data ones count is odd
// - odd parity: parity bit one when data ones count is even
// - spi mode: eight data bits, msb or lsb first by setting
// - spi mode: next frame may follow directly, else line idles high
// - enabled transmitter owns the output pin, driving the shift register bit
// - buffer moves to shifter when idle or right after last stop bit
// - transmit complete set when frame done and buffer empty
// - unused upper write bits ignored; ninth bit written before low byte
// - transmitter disable waits for empty shifter and buffer, then pin goes input
// - receiver samples bits after start up to first stop; second stop ignored
// - on first stop, character enters receive buffer and complete flag sets
// - unused upper read bits are zero; ninth bit read before low byte
// - error flags travel in fifo with character; reading data advances fifo
// - parity checker flags mismatch between computed and received parity
// - receiver disable is immediate, flushing buffer and current frame
// - receiver oversamples sixteen times, or eight in double speed
// - start accepted if two of samples 8-10 (4-6) are low
// - each data, parity and stop bit decided by three-sample majority
// - frame error when voted first stop bit is zero
// - next start edge detected right after first stop vote sample
module usrt_datapath
    import usrt_pkg::*;
#(
    parameter int RX_DEPTH = USRT_RX_DEPTH
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic tx_en_i,
    input wire logic rx_en_i,
    input wire logic [2:0] char_size_i,
    input wire logic [1:0] parity_mode_i,
    input wire logic two_stop_i,
    input wire logic spi_mode_i,
    input wire logic spi_msb_first_i,
    input wire logic dbl_speed_i,
    // oversample tick from the baud generator
    input wire logic sample_tick_i,
    // transmit side
    input wire logic [7:0] tx_data_i,
    input wire logic tx_ninth_bit_i,
    input wire logic tx_write_i,
    input wire logic tx_complete_clr_i,
    output logic data_empty_flag_o,
    output logic tx_complete_flag_o,
    // normal port control of the output pin
    input wire logic port_out_i,
    input wire logic port_dir_i,
    input wire logic port_dir_set_i,
    // serial pins
    output logic serial_out_o,
    output logic serial_out_oe_o,
    input wire logic serial_in_i,
    // receive side
    input wire logic rx_read_i,
    output logic [7:0] rx_data_o,
    output logic rx_ninth_bit_o,
    output logic rx_complete_flag_o,
    output logic frame_error_flag_o,
    output logic overflow_flag_o,
    output logic parity_error_flag_o
);

    localparam int CW = $clog2(RX_DEPTH + 1);

    if (RX_DEPTH < 1) begin : g_depth_check
        $error("usrt_datapath: RX_DEPTH must be at least one");
    end

    typedef enum logic [1:0] {
        USRT_IDLE,
        USRT_START,
        USRT_BITS
    } usrt_rx_e;

    typedef struct packed {
        logic tx_act;
        logic dir_in;
        logic txb_full;
        logic [8:0] txb_data;
        logic tx_busy;
        logic [USRT_FRAME_W-1:0] tx_sh;
        logic [3:0] tx_left;
        logic [4:0] tx_tick;
        logic txc;
        logic pin;
        logic oe;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        usrt_rx_e rx_st;
        logic [4:0] rx_smp;
        logic [1:0] rx_ones;
        logic [3:0] rx_idx;
        logic [8:0] rx_dat;
        logic rx_par;
        logic [CW-1:0] fcnt;
        logic [RX_DEPTH-1:0][USRT_ENTRY_W-1:0] fifo;
        logic rx_ready;
    } usrt_state_s;

    usrt_state_s s;
    usrt_state_s next_s;

    // keeps only the configured number of data bits
    function automatic logic [8:0] usrt_mask(input logic [3:0] nbits);
        logic [8:0] m;
        m = '0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nbits) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    always_comb begin
        logic [3:0] nb;
        logic [4:0] spb;
        logic [4:0] tspb;
        logic [4:0] vf;
        logic par_en;
        logic tx_end;
        logic [8:0] wd;
        logic [4:0] smp;
        logic maj;
        logic [USRT_ENTRY_W-1:0] ent;
        nb = USRT_MIN_BITS + {1'b0, char_size_i};
        spb = dbl_speed_i ? USRT_SPB_DOUBLE : USRT_SPB_NORMAL;
        vf = dbl_speed_i ? USRT_VOTE_DOUBLE : USRT_VOTE_NORMAL;
        tspb = spi_mode_i ? 5'h01 : spb;
        par_en = parity_mode_i[1];
        tx_end = 1'b0;
        wd = '0;
        smp = '0;
        maj = 1'b0;
        ent = '0;
        next_s = s;

        // transmitter enable and pin ownership
        if (tx_en_i) begin
            next_s.tx_act = 1'b1;
        end else if (!s.tx_busy && !s.txb_full) begin
            next_s.tx_act = 1'b0;
            if (s.tx_act) begin
                next_s.dir_in = 1'b1;
            end
        end
        if (port_dir_set_i) begin
            next_s.dir_in = 1'b0;
        end
        if (tx_complete_clr_i) begin
            next_s.txc = 1'b0;
        end
        // a write to a full buffer is dropped
        if (tx_write_i && tx_en_i && !s.txb_full) begin
            next_s.txb_full = 1'b1;
            next_s.txb_data = {tx_ninth_bit_i, tx_data_i};
        end

        // bit timing of the shifter
        if (s.tx_busy && sample_tick_i) begin
            if (s.tx_tick == tspb - 5'h01) begin
                next_s.tx_tick = '0;
                next_s.tx_sh = {USRT_RST_LINE, s.tx_sh[USRT_FRAME_W-1:1]};
                next_s.tx_left = s.tx_left - 4'h1;
                tx_end = (s.tx_left == 4'h1);
            end else begin
                next_s.tx_tick = s.tx_tick + 5'h01;
            end
        end

        if (s.txb_full && s.tx_act && (!s.tx_busy || tx_end)) begin
            next_s.tx_busy = 1'b1;
            next_s.txb_full = 1'b0;
            next_s.tx_tick = '0;
            next_s.tx_sh = '1;
            if (spi_mode_i) begin
                for (int i = 0; i < 8; i++) begin
                    next_s.tx_sh[i] = spi_msb_first_i ? s.txb_data[7-i] : s.txb_data[i];
                end
                next_s.tx_left = USRT_SPI_BITS;
            end else begin
                wd = s.txb_data & usrt_mask(nb);
                next_s.tx_sh[0] = 1'b0;
                for (int i = 0; i < 9; i++) begin
                    if (4'(i) < nb) begin
                        next_s.tx_sh[i+1] = wd[i];
                    end
                end
                if (par_en) begin
                    next_s.tx_sh[nb+4'h1] = (^wd) ^ parity_mode_i[0];
                end
                next_s.tx_left = USRT_START_STOP + nb + {3'h0, par_en} + {3'h0, two_stop_i};
            end
        end else if (tx_end) begin
            next_s.tx_busy = 1'b0;
            next_s.txc = 1'b1;
        end

        // pin drive follows the next state so pin and shifter stay aligned
        next_s.pin = next_s.tx_act ? (next_s.tx_busy ? next_s.tx_sh[0] : USRT_RST_LINE) : port_out_i;
        next_s.oe = next_s.tx_act | (port_dir_i & ~next_s.dir_in);

        // receive line synchroniser
        next_s.rx_s1 = serial_in_i;
        next_s.rx_s2 = s.rx_s1;

        // reading the data location pops the head entry
        if (rx_read_i && s.fcnt != '0) begin
            for (int i = 0; i < RX_DEPTH - 1; i++) begin
                next_s.fifo[i] = s.fifo[i+1];
            end
            next_s.fifo[RX_DEPTH-1] = '0;
            next_s.fcnt = s.fcnt - CW'(1);
        end

        if (!rx_en_i) begin
            next_s.rx_st = USRT_IDLE;
            next_s.fcnt = '0;
            // flushed entries must not linger on the head outputs
            next_s.fifo = '0;
            next_s.rx_prev = USRT_RST_LINE;
        end else if (sample_tick_i && !spi_mode_i) begin
            smp = (s.rx_smp == spb) ? 5'h01 : s.rx_smp + 5'h01;
            if (smp >= vf && smp <= vf + USRT_VOTE_SPAN) begin
                next_s.rx_ones = s.rx_ones + {1'b0, s.rx_s2};
            end
            maj = (3'(s.rx_ones) + 3'(s.rx_s2)) >= 3'h2;
            unique case (s.rx_st)
                USRT_IDLE: begin
                    next_s.rx_prev = s.rx_s2;
                    if (s.rx_prev && !s.rx_s2) begin
                        next_s.rx_st = USRT_START;
                        next_s.rx_smp = 5'h01;
                        next_s.rx_ones = '0;
                    end
                end
                USRT_START: begin
                    next_s.rx_smp = smp;
                    if (smp == vf + USRT_VOTE_SPAN) begin
                        next_s.rx_ones = '0;
                        if (!maj) begin
                            next_s.rx_st = USRT_BITS;
                            next_s.rx_idx = '0;
                            next_s.rx_dat = '0;
                        end else begin
                            next_s.rx_st = USRT_IDLE;
                            next_s.rx_prev = s.rx_s2;
                        end
                    end
                end
                USRT_BITS: begin
                    next_s.rx_smp = smp;
                    if (smp == vf + USRT_VOTE_SPAN) begin
                        next_s.rx_ones = '0;
                        next_s.rx_idx = s.rx_idx + 4'h1;
                        if (s.rx_idx < nb) begin
                            next_s.rx_dat[s.rx_idx] = maj;
                        end else if (s.rx_idx == nb && par_en) begin
                            next_s.rx_par = maj;
                        end else begin
                            // first stop voted: hunt for the next edge now
                            next_s.rx_st = USRT_IDLE;
                            next_s.rx_prev = maj;
                            ent[8:0] = s.rx_dat & usrt_mask(nb);
                            ent[USRT_E_FRAME_ERROR_FLAG] = ~maj;
                            ent[USRT_E_PARITY_ERROR_FLAG] = par_en & (s.rx_par != ((^s.rx_dat) ^ parity_mode_i[0]));
                            if (next_s.fcnt < CW'(RX_DEPTH)) begin
                                next_s.fifo[next_s.fcnt] = ent;
                                next_s.fcnt = next_s.fcnt + CW'(1);
                            end else begin
                                next_s.fifo[RX_DEPTH-1][USRT_E_OVF] = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
        next_s.rx_ready = (next_s.fcnt != '0);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.tx_sh <= '1;
            s.pin <= USRT_RST_LINE;
            s.rx_s1 <= USRT_RST_LINE;
            s.rx_s2 <= USRT_RST_LINE;
            s.rx_prev <= USRT_RST_LINE;
            s.rx_st <= USRT_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign data_empty_flag_o = ~s.txb_full;
    assign tx_complete_flag_o = s.txc;
    assign serial_out_o = s.pin;
    assign serial_out_oe_o = s.oe;
    assign rx_data_o = s.fifo[0][7:0];
    assign rx_ninth_bit_o = s.fifo[0][USRT_E_NINTH];
    assign frame_error_flag_o = s.fifo[0][USRT_E_FRAME_ERROR_FLAG];
    assign parity_error_flag_o = s.fifo[0][USRT_E_PARITY_ERROR_FLAG];
    assign overflow_flag_o = s.fifo[0][USRT_E_OVF];
    assign rx_complete_flag_o = s.rx_ready;

endmodule

// ### usrt_datapath_sva.sv
// port-level assertions for the serial datapath
`timescale 1ns/1ps
module usrt_datapath_sva #(
    parameter int RX_DEPTH = 2
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // controls
    input wire logic tx_en_i,
    input wire logic rx_en_i,
    input wire logic spi_mode_i,
    input wire logic tx_write_i,
    input wire logic tx_complete_clr_i,
    // observed outputs
    input wire logic data_empty_flag_o,
    input wire logic tx_complete_flag_o,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic [7:0] rx_data_o,
    input wire logic rx_ninth_bit_o,
    input wire logic rx_complete_flag_o,
    input wire logic frame_error_flag_o,
    input wire logic overflow_flag_o,
    input wire logic parity_error_flag_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_taken;
        tx_write_i && tx_en_i && data_empty_flag_o;
    endsequence
    // buffer emptying means the shifter just took a character
    sequence s_load;
        !data_empty_flag_o ##1 data_empty_flag_o;
    endsequence
    a_write_taken: assert property (s_taken |=> !data_empty_flag_o)
        else $error("accepted write left buffer empty");
    a_start_bit: assert property (s_load |-> (!serial_out_o || spi_mode_i))
        else $error("load without low start bit");
    a_rx_empty_zero: assert property (!rx_complete_flag_o |-> rx_data_o == 8'h00 && !rx_ninth_bit_o
        && !frame_error_flag_o && !overflow_flag_o && !parity_error_flag_o)
        else $error("empty fifo shows nonzero entry");
    a_rx_disable: assert property (!rx_en_i |=> !rx_complete_flag_o)
        else $error("receive data kept while disabled");
    a_tc_sticky: assert property (tx_complete_flag_o && !tx_complete_clr_i |=> tx_complete_flag_o)
        else $error("transmit complete dropped by itself");
    a_stop_high: assert property ($rose(tx_complete_flag_o) |-> serial_out_o)
        else $error("line not high at frame end");
    a_oe_owned: assert property (tx_en_i [*3] |-> serial_out_oe_o)
        else $error("enabled transmitter not driving pin");
    a_oe_busy: assert property (serial_out_oe_o && !data_empty_flag_o |=> serial_out_oe_o)
        else $error("pin released with pending character");
endmodule
bind usrt_datapath usrt_datapath_sva #(.RX_DEPTH(RX_DEPTH)) u_sva (.*);

// ### usrt_remote.sv
// remote serial transceiver on the far side of the pins
`timescale 1ns/1ps
module usrt_remote (
    // clock and oversample tick
    input wire logic sys_clk_i,
    input wire logic sample_tick_i,
    // serial lines
    input wire logic serial_out_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // n bits lsb first, each held spb ticks, then idle high
    task automatic send(input logic [12:0] bits, input int n, input int spb);
        for (int i = 0; i < n; i++) begin
            line_o = bits[i];
            repeat (spb) @(posedge sys_clk_i iff sample_tick_i);
            #1;
        end
        line_o = 1'b1;
    endtask
    // sample mid-bit, starting from the load moment
    task automatic grab(input int n, input int spb, output logic [12:0] bits);
        bits = '0;
        repeat (spb / 2) @(posedge sys_clk_i iff sample_tick_i);
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (spb) @(posedge sys_clk_i iff sample_tick_i);
            #1 bits[i] = serial_out_i;
        end
    endtask
endmodule

// ### usrt_datapath_tb.sv
// self-checking bench for the serial datapath
`timescale 1ns/1ps
module usrt_datapath_tb;
    import usrt_pkg::*;
    logic sys_clk_i = 0, rst_i = 1, tx_en_i = 0, rx_en_i = 0, two_stop_i = 0, spi_mode_i = 0;
    logic spi_msb_first_i = 0, dbl_speed_i = 0, sample_tick_i = 0, tx_ninth_bit_i = 0, tx_write_i = 0;
    logic tx_complete_clr_i = 0, port_dir_set_i = 0, rx_read_i = 0, serial_in, serial_out, oe;
    logic [2:0] char_size_i = 0;
    logic [1:0] parity_mode_i = 0;
    logic [7:0] tx_data_i = 0, rx_data;
    logic rx_ninth, rx_done, frame_error_flag, ovf, parity_error_flag, empty, tdone;
    int errors = 0, tests_run = 0;
    logic [1:0] pars [3] = '{USRT_PAR_NONE, USRT_PAR_EVEN, USRT_PAR_ODD};
    always #50 sys_clk_i = ~sys_clk_i;
    always @(negedge sys_clk_i) sample_tick_i <= ~sample_tick_i;
    usrt_datapath u_usrt_datapath (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tx_en_i(tx_en_i), .rx_en_i(rx_en_i),
        .char_size_i(char_size_i), .parity_mode_i(parity_mode_i), .two_stop_i(two_stop_i), .spi_mode_i(spi_mode_i),
        .spi_msb_first_i(spi_msb_first_i), .dbl_speed_i(dbl_speed_i), .sample_tick_i(sample_tick_i),
        .tx_data_i(tx_data_i), .tx_ninth_bit_i(tx_ninth_bit_i), .tx_write_i(tx_write_i),
        .tx_complete_clr_i(tx_complete_clr_i), .data_empty_flag_o(empty), .tx_complete_flag_o(tdone),
        .port_out_i(1'b1), .port_dir_i(1'b1), .port_dir_set_i(port_dir_set_i), .serial_out_o(serial_out),
        .serial_out_oe_o(oe), .serial_in_i(serial_in), .rx_read_i(rx_read_i), .rx_data_o(rx_data),
        .rx_ninth_bit_o(rx_ninth), .rx_complete_flag_o(rx_done), .frame_error_flag_o(frame_error_flag),
        .overflow_flag_o(ovf), .parity_error_flag_o(parity_error_flag));
    usrt_remote u_usrt_remote (.sys_clk_i(sys_clk_i), .sample_tick_i(sample_tick_i), .serial_out_i(serial_out),
        .line_o(serial_in));
    function automatic int build(input logic [8:0] d, input int nb, input logic [1:0] par, input logic two,
        input logic spi, input logic msb, output logic [12:0] b);
        int n;
        b = '1;
        if (spi) begin
            for (int i = 0; i < 8; i++) b[i] = msb ? d[7 - i] : d[i];
            return 8;
        end
        b[0] = 1'b0;
        for (int i = 0; i < nb; i++) b[1 + i] = d[i];
        n = 1 + nb;
        if (par[1]) begin
            b[n] = par[0] ^ (^(d & ((9'h001 << nb) - 9'h001)));
            n++;
        end
        return n + 1 + int'(two);
    endfunction
    task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk_i) s = 1'b1;
        @(negedge sys_clk_i) s = 1'b0;
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #5_000_000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end
    initial begin
        logic [8:0] d;
        logic [12:0] b, got;
        int n, nb, spb, err, pos;
        repeat (10) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_i = 0;
        void'($urandom(69));
        @(negedge sys_clk_i) tx_en_i = 1;
        rx_en_i = 1;
        for (int k = 0; k < 20; k++) begin
            d = 9'($urandom);
            nb = 5 + k % 5;
            spi_mode_i = (k % 7 == 6);
            spi_msb_first_i = k[3];
            @(negedge sys_clk_i) {char_size_i, parity_mode_i} = {3'(nb - 5), pars[k % 3]};
            {two_stop_i, dbl_speed_i} = 2'($urandom);
            spb = spi_mode_i ? 1 : (dbl_speed_i ? 8 : 16);
            n = build(d, nb, parity_mode_i, two_stop_i, spi_mode_i, spi_msb_first_i, b);
            {tx_ninth_bit_i, tx_data_i} = d;
            pulse(tx_write_i);
            @(posedge sys_clk_i);
            u_usrt_remote.grab(n, spb, got);
            check(got, b & ((13'h0001 << n) - 13'h0001), "tx frame");
            for (int t = 0; t < 200 && tdone !== 1'b1; t++) @(posedge sys_clk_i);
            check({12'h000, tdone}, 13'h0001, "tx complete");
            pulse(tx_complete_clr_i);
            if (!spi_mode_i) begin
                err = k % 4;
                pos = 1 + nb + int'(parity_mode_i[1]);
                if (err == 1 && parity_mode_i[1]) b[pos - 1] = ~b[pos - 1];
                if (err == 2) b[pos] = 1'b0;
                u_usrt_remote.send(b, n, spb);
                for (int t = 0; t < 40 && rx_done !== 1'b1; t++) @(posedge sys_clk_i);
                check({rx_done, parity_error_flag, frame_error_flag, rx_ninth, rx_data},
                    {1'b1, err == 1 && parity_mode_i[1], err == 2, nb == 9 && d[8], 8'(d & ((9'h001 << nb) - 9'h001))},
                    "rx frame");
                pulse(rx_read_i);
                check({12'h000, rx_done}, 13'h0000, "rx pop");
            end
            $display("test %0d done", k);
        end
        spi_mode_i = 0;
        // three frames into a two-entry fifo: the newest stored entry is marked
        repeat (3) u_usrt_remote.send(b, n, spb);
        @(negedge sys_clk_i);
        check({11'h000, rx_done, ovf}, 13'h0002, "overflow head");
        pulse(rx_read_i);
        check({11'h000, rx_done, ovf}, 13'h0003, "overflow newest");
        $display("test overflow done");
        @(negedge sys_clk_i) rx_en_i = 0;
        repeat (2) @(negedge sys_clk_i);
        check({12'h000, rx_done}, 13'h0000, "rx disable flush");
        tx_en_i = 0;
        repeat (4) @(negedge sys_clk_i);
        check({12'h000, oe}, 13'h0000, "tx disable release");
        pulse(port_dir_set_i);
        @(negedge sys_clk_i);
        check({12'h000, oe}, 13'h0001, "port direction restored");
        $display("test disable done");
        close_out();
    end
endmodule
